// file: design/aqg_pkg.sv
// Shared constants, types and decode helpers for the alert qualifier block
package aqg_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] AQG_ADDR_CHANNEL_ALERT_MASK = 8'h1F;
  localparam logic [7:0] AQG_ADDR_CRIT_HYSTERESIS = 8'h21;
  localparam logic [7:0] AQG_ADDR_CONSECUTIVE_COUNT_CONTROL = 8'h22;
  localparam logic [7:0] AQG_ADDR_EXTERNAL_GAIN_COMPENSATION = 8'h25;

  // Reset values
  localparam logic [7:0] AQG_RST_CHANNEL_ALERT_MASK = 8'h00;
  localparam logic [7:0] AQG_RST_CRIT_HYSTERESIS = 8'h0A;
  localparam logic [7:0] AQG_RST_CONSECUTIVE_COUNT_CONTROL = 8'h70;
  localparam logic [7:0] AQG_RST_EXTERNAL_GAIN_COMPENSATION = 8'h08;

  // Field positions
  localparam int AQG_BIT_INT_BLOCK = 0;
  localparam int AQG_BIT_EXT_BLOCK = 1;
  localparam int AQG_BIT_TIMEOUT_EN = 7;
  localparam int AQG_LSB_CRIT_SEL = 4;
  localparam int AQG_LSB_ALERT_SEL = 1;
  localparam int AQG_BIT_AUTO_EN = 3;
  localparam int AQG_LSB_GAIN = 0;

  // Gain code that switches compensation off while autodetect is disabled
  localparam logic [2:0] AQG_GAIN_OFF = 3'h7;

  // Serial address of this device; value is arbitrary
  localparam logic [6:0] AQG_DEV_ADDR = 7'h2A;

  // Clock-low timeout
  localparam int AQG_SYS_CLK_HZ = 50_000_000;
  localparam int AQG_SMB_TIMEOUT_MS = 30;
  localparam int AQG_SMB_TIMEOUT_CYC = (AQG_SYS_CLK_HZ / 1000) * AQG_SMB_TIMEOUT_MS;
  localparam int AQG_TO_W = 21;

  // Serial engine states
  typedef enum logic [2:0] {
    AQG_IDLE,
    AQG_ADDR,
    AQG_CMD,
    AQG_WDATA,
    AQG_ACK,
    AQG_RDATA,
    AQG_MACK
  } aqg_smb_e;

  // Count field decode: 000=1, 001=2, 011=3, 111=4, others 4
  function automatic logic [2:0] aqg_count_target(input logic [2:0] sel);
    case (sel)
      3'h0: return 3'h1;
      3'h1: return 3'h2;
      3'h3: return 3'h3;
      default: return 3'h4;
    endcase
  endfunction

endpackage

// file: design/aqg_channel_qualify.sv
// Per-channel consecutive alert and critical counters
`timescale 1ns/1ps
module aqg_channel_qualify import aqg_pkg::*; (
  input wire logic sys_clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic meas, // One-cycle pulse, new reading
  input wire logic comp_mode, // Comparator behaviour selected
  input wire logic [7:0] temp, // Measured temperature
  input wire logic [7:0] high_limit, // High limit
  input wire logic [7:0] low_limit, // Low limit
  input wire logic [7:0] crit_limit, // Critical limit
  input wire logic [7:0] hyst, // Release hysteresis
  input wire logic fault, // Diode fault on this reading
  input wire logic [2:0] alert_sel, // Alert count field
  input wire logic [2:0] crit_sel, // Critical count field
  output logic alert_hit, // Interrupt-mode trigger, with meas
  output logic is_high, // Reading above high limit
  output logic is_low, // Reading at or below low limit
  output logic alert_active, // Comparator alert held
  output logic crit_active // Critical condition held
);

  typedef struct packed {
    logic [2:0] alert_cnt, crit_cnt;
    logic alert_act, crit_act;
  } aqg_chan_s;

  aqg_chan_s st_reg, st_next;
  logic over_crit, rel_high, rel_crit, alert_cond;
  logic [2:0] alert_inc, crit_inc;

  // Counter updates on each reading
  always_comb begin
    st_next = st_reg;
    is_high = temp > high_limit;
    is_low = temp <= low_limit;
    over_crit = temp > crit_limit;
    rel_high = ({1'b0, temp} + {1'b0, hyst}) < {1'b0, high_limit};
    rel_crit = ({1'b0, temp} + {1'b0, hyst}) < {1'b0, crit_limit};
    alert_cond = comp_mode ? is_high : (is_high | is_low | fault);
    alert_inc = st_reg.alert_cnt + 3'h1;
    crit_inc = st_reg.crit_cnt + 3'h1;
    alert_hit = meas && !comp_mode && alert_cond && (alert_inc >= aqg_count_target(alert_sel));
    if (meas) begin
      if (comp_mode) begin
        if (st_reg.alert_act) begin
          if (rel_high) begin
            st_next.alert_act = 1'b0;
            st_next.alert_cnt = 3'h0;
          end
        end else if (alert_cond) begin
          st_next.alert_cnt = alert_inc;
          if (alert_inc >= aqg_count_target(alert_sel)) begin
            st_next.alert_act = 1'b1;
          end
        end else begin
          st_next.alert_cnt = 3'h0;
        end
      end else begin
        st_next.alert_act = 1'b0;
        st_next.alert_cnt = (alert_cond && !alert_hit) ? alert_inc : 3'h0;
      end
      if (st_reg.crit_act) begin
        if (rel_crit) begin
          st_next.crit_act = 1'b0;
          st_next.crit_cnt = 3'h0;
        end
      end else if (over_crit) begin
        st_next.crit_cnt = crit_inc;
        if (crit_inc >= aqg_count_target(crit_sel)) begin
          st_next.crit_act = 1'b1;
        end
      end else begin
        st_next.crit_cnt = 3'h0;
      end
    end
    alert_active = st_reg.alert_act;
    crit_active = st_reg.crit_act;
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// file: design/aqg_alert_qualify.sv
// Alert and critical qualification with serial register port
`timescale 1ns/1ps
module aqg_alert_qualify import aqg_pkg::*; #(
  parameter int SMB_TIMEOUT_CYCLES = AQG_SMB_TIMEOUT_CYC // Clock-low timeout in cycles
) (
  input wire logic sys_clk, // 50 MHz system clock
  input wire logic reset_n, // Async reset, active low
  input wire logic serial_clock_line, // Serial clock pin
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive level
  output logic sda_oe, // Serial data drive enable
  input wire logic meas_done, // Pulse: new readings valid
  input wire logic conv_start, // Pulse: conversion begins
  input wire logic comp_mode, // Comparator alert behaviour
  input wire logic mask_all, // Global alert mask
  input wire logic status_clear, // Pulse: status read clears flags
  input wire logic [7:0] int_temp, // Internal temperature
  input wire logic [7:0] int_high_limit, // Internal high limit
  input wire logic [7:0] int_low_limit, // Internal low limit
  input wire logic [7:0] int_crit_limit, // Internal critical limit
  input wire logic [7:0] ext_temp, // External temperature
  input wire logic [7:0] ext_high_limit, // External high limit
  input wire logic [7:0] ext_low_limit, // External low limit
  input wire logic [7:0] ext_crit_limit, // External critical limit
  input wire logic ext_fault, // External diode fault
  input wire logic [2:0] gain_best, // Autodetected gain setting
  output logic alert_out, // Alert pin drive level
  output logic alert_oe, // Alert pin pulled low
  output logic crit_out, // Critical pin drive level
  output logic crit_oe, // Critical pin pulled low
  output logic int_status, // Internal channel status
  output logic ext_status, // External channel status
  output logic int_high_flag, // Internal high error
  output logic int_low_flag, // Internal low error
  output logic ext_high_flag, // External high error
  output logic ext_low_flag, // External low error
  output logic ext_fault_flag, // External fault error
  output logic [2:0] gain_setting, // Gain setting in use
  output logic gain_comp_off, // Compensation disabled
  output logic smb_timeout // Pulse: protocol reset by timeout
);

  typedef struct packed {
    logic [2:0] scl_sy, sda_sy;
    aqg_smb_e smb_st, after_st;
    logic [3:0] bitcnt;
    logic [7:0] shreg, ptr, hyst;
    logic [AQG_TO_W-1:0] to_cnt;
    logic [2:0] crit_sel, alert_sel, gain;
    logic mack, sda_oe, to_fire, int_block, ext_block, to_en, auto_en, comp_off;
    logic int_status, ext_status, int_high_flag, int_low_flag, ext_high_flag;
    logic ext_low_flag, ext_fault_flag, alert_latch, alert_oe, crit_oe;
  } aqg_top_s;

  localparam logic [AQG_TO_W-1:0] TO_LIMIT = AQG_TO_W'(SMB_TIMEOUT_CYCLES);
  aqg_top_s st_reg, st_next;
  logic int_hit, int_high, int_low, int_act, int_crit, int_alert;
  logic ext_hit, ext_high, ext_low, ext_act, ext_crit, ext_alert;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic [7:0] rd_byte;

  // Internal channel, no diode fault
  aqg_channel_qualify u_int (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .meas(meas_done),
    .comp_mode(comp_mode),
    .temp(int_temp),
    .high_limit(int_high_limit),
    .low_limit(int_low_limit),
    .crit_limit(int_crit_limit),
    .hyst(st_reg.hyst),
    .fault(1'b0),
    .alert_sel(st_reg.alert_sel),
    .crit_sel(st_reg.crit_sel),
    .alert_hit(int_hit),
    .is_high(int_high),
    .is_low(int_low),
    .alert_active(int_act),
    .crit_active(int_crit)
  );

  // External channel counters
  aqg_channel_qualify u_ext (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .meas(meas_done),
    .comp_mode(comp_mode),
    .temp(ext_temp),
    .high_limit(ext_high_limit),
    .low_limit(ext_low_limit),
    .crit_limit(ext_crit_limit),
    .hyst(st_reg.hyst),
    .fault(ext_fault),
    .alert_sel(st_reg.alert_sel),
    .crit_sel(st_reg.crit_sel),
    .alert_hit(ext_hit),
    .is_high(ext_high),
    .is_low(ext_low),
    .alert_active(ext_act),
    .crit_active(ext_crit)
  );

  // Register read mux, unused bits and offsets read zero
  always_comb begin
    case (st_reg.ptr)
      AQG_ADDR_CHANNEL_ALERT_MASK: rd_byte = {6'h00, st_reg.ext_block, st_reg.int_block};
      AQG_ADDR_CRIT_HYSTERESIS: rd_byte = st_reg.hyst;
      AQG_ADDR_CONSECUTIVE_COUNT_CONTROL:
        rd_byte = {st_reg.to_en, st_reg.crit_sel, st_reg.alert_sel, 1'b0};
      AQG_ADDR_EXTERNAL_GAIN_COMPENSATION: rd_byte = {4'h0, st_reg.auto_en, st_reg.gain};
      default: rd_byte = 8'h00;
    endcase
  end

  // Next state: serial engine, registers, qualification
  always_comb begin
    st_next = st_reg;
    st_next.scl_sy = {st_reg.scl_sy[1:0], serial_clock_line};
    st_next.sda_sy = {st_reg.sda_sy[1:0], sda_in};
    scl_rise = st_reg.scl_sy[1] && !st_reg.scl_sy[2];
    scl_fall = !st_reg.scl_sy[1] && st_reg.scl_sy[2];
    start_seen = st_reg.scl_sy[1] && st_reg.scl_sy[2] && !st_reg.sda_sy[1] && st_reg.sda_sy[2];
    stop_seen = st_reg.scl_sy[1] && st_reg.scl_sy[2] && st_reg.sda_sy[1] && !st_reg.sda_sy[2];
    st_next.to_fire = 1'b0;
    // Serial byte engine
    if (start_seen) begin
      st_next.smb_st = AQG_ADDR;
      st_next.bitcnt = 4'h0;
      st_next.sda_oe = 1'b0;
    end else if (stop_seen) begin
      st_next.smb_st = AQG_IDLE;
      st_next.sda_oe = 1'b0;
    end else begin
      case (st_reg.smb_st)
        AQG_ADDR, AQG_CMD, AQG_WDATA: begin
          if (scl_rise) begin
            st_next.shreg = {st_reg.shreg[6:0], st_reg.sda_sy[1]};
            st_next.bitcnt = st_reg.bitcnt + 4'h1;
          end else if (scl_fall && st_reg.bitcnt == 4'h8) begin
            st_next.bitcnt = 4'h0;
            st_next.sda_oe = 1'b1;
            st_next.smb_st = AQG_ACK;
            if (st_reg.smb_st == AQG_ADDR) begin
              if (st_reg.shreg[7:1] != AQG_DEV_ADDR) begin
                st_next.sda_oe = 1'b0;
                st_next.smb_st = AQG_IDLE;
              end
              st_next.after_st = st_reg.shreg[0] ? AQG_RDATA : AQG_CMD;
            end else if (st_reg.smb_st == AQG_CMD) begin
              st_next.ptr = st_reg.shreg;
              st_next.after_st = AQG_WDATA;
            end else begin
              st_next.after_st = AQG_WDATA;
              case (st_reg.ptr)
                AQG_ADDR_CHANNEL_ALERT_MASK: begin
                  st_next.ext_block = st_reg.shreg[AQG_BIT_EXT_BLOCK];
                  st_next.int_block = st_reg.shreg[AQG_BIT_INT_BLOCK];
                end
                AQG_ADDR_CRIT_HYSTERESIS: st_next.hyst = st_reg.shreg;
                AQG_ADDR_CONSECUTIVE_COUNT_CONTROL: begin
                  st_next.to_en = st_reg.shreg[AQG_BIT_TIMEOUT_EN];
                  st_next.crit_sel = st_reg.shreg[AQG_LSB_CRIT_SEL +: 3];
                  st_next.alert_sel = st_reg.shreg[AQG_LSB_ALERT_SEL +: 3];
                end
                AQG_ADDR_EXTERNAL_GAIN_COMPENSATION: begin
                  st_next.auto_en = st_reg.shreg[AQG_BIT_AUTO_EN];
                  if (!st_reg.shreg[AQG_BIT_AUTO_EN]) begin
                    st_next.gain = st_reg.shreg[AQG_LSB_GAIN +: 3];
                  end
                end
                default: st_next.ptr = st_reg.ptr;
              endcase
            end
          end
        end
        AQG_ACK: begin
          if (scl_fall) begin
            st_next.smb_st = st_reg.after_st;
            st_next.sda_oe = 1'b0;
            if (st_reg.after_st == AQG_RDATA) begin
              st_next.shreg = rd_byte;
              st_next.sda_oe = !rd_byte[7];
            end
          end
        end
        AQG_RDATA: begin
          if (scl_fall) begin
            if (st_reg.bitcnt == 4'h7) begin
              st_next.bitcnt = 4'h0;
              st_next.sda_oe = 1'b0;
              st_next.smb_st = AQG_MACK;
            end else begin
              st_next.bitcnt = st_reg.bitcnt + 4'h1;
              st_next.shreg = {st_reg.shreg[6:0], 1'b0};
              st_next.sda_oe = !st_reg.shreg[6];
            end
          end
        end
        AQG_MACK: begin
          if (scl_rise) begin
            st_next.mack = !st_reg.sda_sy[1];
          end else if (scl_fall) begin
            st_next.smb_st = st_reg.mack ? AQG_RDATA : AQG_IDLE;
            st_next.shreg = rd_byte;
            st_next.sda_oe = st_reg.mack && !rd_byte[7];
          end
        end
        default: st_next.sda_oe = 1'b0;
      endcase
    end
    // Clock-low timeout
    if (!st_reg.to_en || st_reg.scl_sy[1]) begin
      st_next.to_cnt = '0;
    end else if (st_reg.to_cnt >= TO_LIMIT) begin
      st_next.to_cnt = '0;
      st_next.to_fire = 1'b1;
      st_next.smb_st = AQG_IDLE;
      st_next.sda_oe = 1'b0;
    end else begin
      st_next.to_cnt = st_reg.to_cnt + AQG_TO_W'(1);
    end
    // Gain compensation autodetect
    if (st_reg.auto_en && conv_start) begin
      st_next.gain = gain_best;
    end
    st_next.comp_off = !st_next.auto_en && (st_next.gain == AQG_GAIN_OFF);
    // Status and last-error flags, set wins over clear
    if (status_clear) begin
      st_next.int_status = 1'b0;
      st_next.ext_status = 1'b0;
      st_next.int_high_flag = 1'b0;
      st_next.int_low_flag = 1'b0;
      st_next.ext_high_flag = 1'b0;
      st_next.ext_low_flag = 1'b0;
      st_next.ext_fault_flag = 1'b0;
      st_next.alert_latch = 1'b0;
    end
    if (int_hit) begin
      st_next.int_status = 1'b1;
      st_next.int_high_flag = st_reg.int_high_flag | int_high;
      st_next.int_low_flag = st_reg.int_low_flag | int_low;
    end
    if (ext_hit) begin
      st_next.ext_status = 1'b1;
      st_next.ext_high_flag = st_reg.ext_high_flag | ext_high;
      st_next.ext_low_flag = st_reg.ext_low_flag | ext_low;
      st_next.ext_fault_flag = st_reg.ext_fault_flag | ext_fault;
    end
    int_alert = int_hit && !st_reg.int_block;
    ext_alert = ext_hit && !st_reg.ext_block;
    if ((int_alert || ext_alert) && !mask_all) begin
      st_next.alert_latch = 1'b1;
    end
    // Pin drive: comparator mode ignores the global mask
    if (comp_mode) begin
      st_next.alert_oe = (int_act && !st_reg.int_block) || (ext_act && !st_reg.ext_block);
    end else begin
      st_next.alert_oe = st_next.alert_latch;
    end
    st_next.crit_oe = int_crit || ext_crit;
  end

  // State register
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
      st_reg.scl_sy <= 3'h7;
      st_reg.sda_sy <= 3'h7;
      st_reg.smb_st <= AQG_IDLE;
      st_reg.after_st <= AQG_IDLE;
      st_reg.int_block <= AQG_RST_CHANNEL_ALERT_MASK[AQG_BIT_INT_BLOCK];
      st_reg.ext_block <= AQG_RST_CHANNEL_ALERT_MASK[AQG_BIT_EXT_BLOCK];
      st_reg.hyst <= AQG_RST_CRIT_HYSTERESIS;
      st_reg.to_en <= AQG_RST_CONSECUTIVE_COUNT_CONTROL[AQG_BIT_TIMEOUT_EN];
      st_reg.crit_sel <= AQG_RST_CONSECUTIVE_COUNT_CONTROL[AQG_LSB_CRIT_SEL +: 3];
      st_reg.alert_sel <= AQG_RST_CONSECUTIVE_COUNT_CONTROL[AQG_LSB_ALERT_SEL +: 3];
      st_reg.auto_en <= AQG_RST_EXTERNAL_GAIN_COMPENSATION[AQG_BIT_AUTO_EN];
      st_reg.gain <= AQG_RST_EXTERNAL_GAIN_COMPENSATION[AQG_LSB_GAIN +: 3];
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register; pin levels sda_out, alert_out and crit_out tied low
  assign sda_out = 1'b0;
  assign sda_oe = st_reg.sda_oe;
  assign alert_out = 1'b0;
  assign alert_oe = st_reg.alert_oe;
  assign crit_out = 1'b0;
  assign crit_oe = st_reg.crit_oe;
  assign int_status = st_reg.int_status;
  assign ext_status = st_reg.ext_status;
  assign int_high_flag = st_reg.int_high_flag;
  assign int_low_flag = st_reg.int_low_flag;
  assign ext_high_flag = st_reg.ext_high_flag;
  assign ext_low_flag = st_reg.ext_low_flag;
  assign ext_fault_flag = st_reg.ext_fault_flag;
  assign gain_setting = st_reg.gain;
  assign gain_comp_off = st_reg.comp_off;
  assign smb_timeout = st_reg.to_fire;

endmodule

// file: dv/aqg_host_model.sv
// Serial register host model for the alert qualifier
`timescale 1ns/1ps
module aqg_host_model import aqg_pkg::*; (
  output logic scl, // Serial clock, high between frames
  output logic m_oe, // Host pulls data low
  input wire logic sda // Resolved data level, pulled up
);
  logic ok = 1'b1; // Every ack arrived
  // Idle bus: clock high, data released
  initial begin
    scl = 1'b1;
    m_oe = 1'b0;
  end
  // One bit, sampled while clock high
  task automatic bt(input logic b, output logic r);
    #20 m_oe = ~b;
    #60 scl = 1'b1;
    #60 r = sda;
    #20 scl = 1'b0;
  endtask
  // Start or repeated start
  task automatic st();
    #20 m_oe = 1'b0;
    #60 scl = 1'b1;
    #80 m_oe = 1'b1;
    #80 scl = 1'b0;
  endtask
  task automatic sp();
    #20 m_oe = 1'b1;
    #60 scl = 1'b1;
    #80 m_oe = 1'b0;
    #80;
  endtask
  // Byte MSB first, ninth bit left released
  task automatic by(input logic [7:0] w, output logic [7:0] r, output logic n);
    for (int i = 7; i >= 0; i--) bt(w[i], r[i]);
    bt(1'b1, n);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    logic [7:0] r;
    logic a, b, c;
    st();
    by({AQG_DEV_ADDR, 1'b0}, r, a);
    by(ad, r, b);
    by(d, r, c);
    sp();
    if (a | b | c) ok = 1'b0;
  endtask
  // Pointer write, then one byte read
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    logic [7:0] r;
    logic a, b, c, n;
    st();
    by({AQG_DEV_ADDR, 1'b0}, r, a);
    by(ad, r, b);
    st();
    by({AQG_DEV_ADDR, 1'b1}, r, c);
    by(8'hFF, d, n);
    sp();
    if (a | b | c) ok = 1'b0;
  endtask
  task automatic hold_low(input int t);
    scl = 1'b0;
    #(t);
    scl = 1'b1;
  endtask
endmodule

// file: dv/aqg_alert_qualify_props.sv
// Port checks for the alert qualifier
`timescale 1ns/1ps
module aqg_alert_qualify_props import aqg_pkg::*; #(
  parameter int SMB_TIMEOUT_CYCLES = AQG_SMB_TIMEOUT_CYC // Clock-low timeout
) (
  input wire logic sys_clk, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic serial_clock_line, // Serial clock
  input wire logic meas_done, // New readings
  input wire logic comp_mode, // Comparator mode
  input wire logic mask_all, // Global mask
  input wire logic status_clear, // Flag clear
  input wire logic sda_out, // Data level
  input wire logic sda_oe, // Data drive
  input wire logic alert_out, // Alert level
  input wire logic alert_oe, // Alert asserted
  input wire logic crit_out, // Critical level
  input wire logic crit_oe, // Critical asserted
  input wire logic int_status, // Internal status
  input wire logic ext_status, // External status
  input wire logic ext_high_flag, // External high
  input wire logic ext_fault_flag, // External fault
  input wire logic [2:0] gain_setting, // Gain in use
  input wire logic gain_comp_off, // Compensation off
  input wire logic smb_timeout // Timeout pulse
);
  int low_cnt; // Clock-low cycles
  // Clock-low length counter
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) low_cnt <= 0;
    else if (serial_clock_line) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_cleared;
    status_clear && !meas_done;
  endsequence
  sequence s_meas2;
    $past(meas_done, 2);
  endsequence
  a_pins_open_drain: assert property (!alert_out && !crit_out && !sda_out)
    else $error("pin level");
  a_gain_off_code: assert property (gain_comp_off |-> gain_setting == AQG_GAIN_OFF)
    else $error("gain off code");
  a_flag_with_status: assert property ($rose(ext_high_flag) |-> ext_status && $past(meas_done))
    else $error("high flag");
  a_clear_flags: assert property (s_cleared |=> !int_status && !ext_status && !ext_fault_flag)
    else $error("flag clear");
  a_crit_rise_time: assert property ($rose(crit_oe) |-> s_meas2)
    else $error("crit rise");
  a_crit_fall_time: assert property ($fell(crit_oe) |-> s_meas2)
    else $error("crit fall");
  a_cmp_alert_time: assert property (comp_mode && $past(comp_mode) && $past(comp_mode, 2)
    && $rose(alert_oe) |-> s_meas2)
    else $error("comp alert");
  a_int_alert_time: assert property (!comp_mode && !$past(comp_mode) && !$past(comp_mode, 2)
    && $rose(alert_oe) |-> $past(meas_done))
    else $error("int alert");
  a_mask_all_block: assert property ((!comp_mode && mask_all && !alert_oe)
    ##1 (!comp_mode && mask_all) |-> !alert_oe)
    else $error("global mask");
  a_timeout_len: assert property (smb_timeout |-> low_cnt >= SMB_TIMEOUT_CYCLES
    ##1 (!smb_timeout && !sda_oe))
    else $error("timeout");
endmodule

// file: dv/test_aqg_alert_qualify.sv
// Self-checking bench for the alert qualifier
`timescale 1ns/1ps
module test_aqg_alert_qualify import aqg_pkg::*;;
  logic sys_clk = 0, reset_n = 0, meas_done = 0, conv_start = 0, comp_mode = 0;
  logic mask_all = 0, status_clear = 0, ext_fault = 0;
  logic [7:0] it = 8'h28, et = 8'h28, hi = 8'h46, lo = 8'h0A, cr = 8'h5A;
  logic [2:0] gain_best = 3'h0, gain_setting;
  wire scl, m_oe, sda_out, sda_oe, alert_out, alert_oe, crit_out, crit_oe, int_status;
  wire ext_status, int_high_flag, int_low_flag, ext_high_flag, ext_low_flag;
  wire ext_fault_flag, gain_comp_off, smb_timeout;
  wire sda = ~(sda_oe | m_oe); // Pulled-up data line
  int failures = 0, checks = 0, to_cnt = 0;
  always #10 sys_clk = ~sys_clk;
  // Timeout pulse counter
  always @(posedge sys_clk) if (smb_timeout === 1'b1) to_cnt <= to_cnt + 1;
  aqg_host_model host_u (.scl, .m_oe, .sda);
  aqg_alert_qualify #(.SMB_TIMEOUT_CYCLES(200)) dut_u (.sys_clk, .reset_n,
    .serial_clock_line(scl), .sda_in(sda), .sda_out, .sda_oe, .meas_done, .conv_start,
    .comp_mode, .mask_all, .status_clear, .int_temp(it), .int_high_limit(hi),
    .int_low_limit(lo), .int_crit_limit(cr), .ext_temp(et), .ext_high_limit(hi),
    .ext_low_limit(lo), .ext_crit_limit(cr), .ext_fault, .gain_best, .alert_out,
    .alert_oe, .crit_out, .crit_oe, .int_status, .ext_status, .int_high_flag,
    .int_low_flag, .ext_high_flag, .ext_low_flag, .ext_fault_flag, .gain_setting,
    .gain_comp_off, .smb_timeout);
  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk("register", d, e);
  endtask
  // One reading, outputs settled
  task automatic ms(input logic [7:0] i, input logic [7:0] e, input logic f);
    @(posedge sys_clk);
    it <= i;
    et <= e;
    ext_fault <= f;
    meas_done <= 1'b1;
    @(posedge sys_clk);
    meas_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // Start (c=1) or clear pulse
  task automatic pl(input bit c);
    @(posedge sys_clk);
    if (c) conv_start <= 1'b1;
    else status_clear <= 1'b1;
    @(posedge sys_clk);
    conv_start <= 1'b0;
    status_clear <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic t_regs();
    rchk(8'h1F, 8'h00);
    rchk(8'h21, 8'h0A);
    rchk(8'h22, 8'h70);
    rchk(8'h25, 8'h08);
    host_u.wr(8'h1F, 8'hFF);
    rchk(8'h1F, 8'h03);
    host_u.wr(8'h1F, 8'h00);
    $display("done regs");
  endtask
  task automatic t_count();
    logic [2:0] c [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
    int n [5] = '{1, 2, 3, 4, 4};
    for (int k = 0; k < 5; k++) begin
      host_u.wr(8'h22, {4'h7, c[k], 1'b0});
      repeat (n[k] - 1) ms(8'h28, 8'h50, 1'b0);
      chk("ext_status", ext_status, 8'h00);
      ms(8'h28, 8'h50, 1'b0);
      chk("ext_status", ext_status, 8'h01);
      pl(0);
    end
    $display("done count");
  endtask
  task automatic t_order();
    host_u.wr(8'h22, 8'h72);
    ms(8'h50, 8'h28, 1'b0);
    ms(8'h50, 8'h50, 1'b0);
    chk("int_status", int_status, 8'h01);
    chk("ext_status", ext_status, 8'h00);
    chk("int_flags", {int_high_flag, int_low_flag}, 8'h02);
    ms(8'h28, 8'h50, 1'b0);
    chk("ext_status", ext_status, 8'h01);
    pl(0);
    ms(8'h50, 8'h28, 1'b0);
    ms(8'h28, 8'h28, 1'b0);
    ms(8'h50, 8'h28, 1'b0);
    chk("int_status", int_status, 8'h00);
    ms(8'h50, 8'h28, 1'b0);
    chk("int_status", int_status, 8'h01);
    pl(0);
    host_u.wr(8'h22, 8'h70);
    $display("done order");
  endtask
  task automatic t_mask();
    host_u.wr(8'h1F, 8'h02);
    ms(8'h28, 8'h50, 1'b0);
    chk("ext_status", ext_status, 8'h01);
    chk("alert_oe", alert_oe, 8'h00);
    ms(8'h28, 8'h08, 1'b1);
    chk("alert_oe", alert_oe, 8'h00);
    chk("ext_flags", {ext_low_flag, ext_fault_flag}, 8'h03);
    ms(8'h50, 8'h28, 1'b0);
    chk("alert_oe", alert_oe, 8'h01);
    pl(0);
    host_u.wr(8'h1F, 8'h01);
    ms(8'h50, 8'h28, 1'b0);
    chk("alert_oe", alert_oe, 8'h00);
    ms(8'h28, 8'h50, 1'b0);
    chk("alert_oe", alert_oe, 8'h01);
    pl(0);
    host_u.wr(8'h1F, 8'h00);
    @(posedge sys_clk) mask_all <= 1'b1;
    ms(8'h28, 8'h50, 1'b0);
    chk("alert_oe", alert_oe, 8'h00);
    @(posedge sys_clk) mask_all <= 1'b0;
    pl(0);
    $display("done mask");
  endtask
  task automatic t_crit();
    host_u.wr(8'h1F, 8'h03);
    repeat (3) ms(8'h28, 8'h60, 1'b0);
    ms(8'h28, 8'h28, 1'b0);
    repeat (3) ms(8'h28, 8'h60, 1'b0);
    chk("crit_oe", crit_oe, 8'h00);
    ms(8'h28, 8'h60, 1'b0);
    chk("crit_oe", crit_oe, 8'h01);
    ms(8'h28, 8'h55, 1'b0);
    chk("crit_oe", crit_oe, 8'h01);
    ms(8'h28, 8'h28, 1'b0);
    chk("crit_oe", crit_oe, 8'h00);
    pl(0);
    host_u.wr(8'h1F, 8'h00);
    $display("done crit");
  endtask
  task automatic t_comp();
    @(posedge sys_clk) comp_mode <= 1'b1;
    ms(8'h28, 8'h28, 1'b1);
    chk("alert_oe", alert_oe, 8'h00);
    ms(8'h28, 8'h08, 1'b0);
    chk("alert_oe", alert_oe, 8'h00);
    ms(8'h28, 8'h50, 1'b0);
    chk("alert_oe", alert_oe, 8'h01);
    @(posedge sys_clk) mask_all <= 1'b1;
    ms(8'h28, 8'h40, 1'b0);
    chk("alert_oe", alert_oe, 8'h01);
    ms(8'h28, 8'h28, 1'b0);
    chk("alert_oe", alert_oe, 8'h00);
    pl(0);
    @(posedge sys_clk) comp_mode <= 1'b0;
    mask_all <= 1'b0;
    $display("done comp");
  endtask
  task automatic t_gain();
    @(posedge sys_clk) gain_best <= 3'h5;
    pl(1);
    chk("gain", gain_setting, 8'h05);
    rchk(8'h25, 8'h0D);
    host_u.wr(8'h25, 8'h03);
    chk("gain", gain_setting, 8'h03);
    @(posedge sys_clk) gain_best <= 3'h6;
    pl(1);
    chk("gain", gain_setting, 8'h03);
    host_u.wr(8'h25, 8'h07);
    chk("comp_off", gain_comp_off, 8'h01);
    host_u.wr(8'h25, 8'h08);
    pl(1);
    chk("gain", gain_setting, 8'h06);
    chk("comp_off", gain_comp_off, 8'h00);
    host_u.wr(8'h25, 8'h0A);
    rchk(8'h25, 8'h0E);
    $display("done gain");
  endtask
  task automatic t_tout();
    int n0;
    host_u.wr(8'h22, 8'hF0);
    n0 = to_cnt;
    host_u.hold_low(6000);
    chk("timeouts", 8'(to_cnt - n0), 8'h01);
    host_u.wr(8'h22, 8'h70);
    n0 = to_cnt;
    host_u.hold_low(6000);
    chk("timeouts", 8'(to_cnt - n0), 8'h00);
    rchk(8'h22, 8'h70);
    $display("done timeout");
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    t_regs();
    t_count();
    t_order();
    t_mask();
    t_crit();
    t_comp();
    t_gain();
    t_tout();
    chk("acks", host_u.ok, 8'h01);
    complete_run();
  end
  // Watchdog
  initial begin
    #1_000_000;
    failures++;
    complete_run();
  end
endmodule
bind aqg_alert_qualify aqg_alert_qualify_props #(.SMB_TIMEOUT_CYCLES(SMB_TIMEOUT_CYCLES)) p_u (
  .sys_clk, .reset_n, .serial_clock_line, .meas_done, .comp_mode, .mask_all, .status_clear,
  .sda_out, .sda_oe, .alert_out, .alert_oe, .crit_out, .crit_oe, .int_status, .ext_status,
  .ext_high_flag, .ext_fault_flag, .gain_setting, .gain_comp_off, .smb_timeout);
